// *** shared/astrl_pkg.sv ***
// Constants and state type for the converter status, trigger and result logic
package astrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RES_W  = 10;
  localparam int unsigned PIN_W  = 8;
  localparam int unsigned PS_W   = 7;

  localparam logic [7:0] OFS_RESULT_LOW  = 8'h78;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h79;
  localparam logic [7:0] OFS_CTRL_A      = 8'h7a;
  localparam logic [7:0] OFS_CTRL_B      = 8'h7b;
  localparam logic [7:0] OFS_INPUT_SEL   = 8'h7c;
  localparam logic [7:0] OFS_PIN_DISABLE = 8'h7e;

  // Control/status A fields
  localparam int unsigned CA_ENABLE  = 7;
  localparam int unsigned CA_START   = 6;
  localparam int unsigned CA_AUTO    = 5;
  localparam int unsigned CA_FLAG    = 4;
  localparam int unsigned CA_IE      = 3;
  localparam int unsigned CA_PS_LSB  = 0;
  // Input select fields
  localparam int unsigned IS_LEFT    = 5;
  localparam int unsigned IS_MUX_LSB = 0;
  // Control/status B field
  localparam int unsigned CB_TS_LSB  = 0;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [2:0] TS_FREE_RUN = 3'h0;
  localparam logic [4:0] MUX_DIFF_LO = 5'h08;
  localparam logic [4:0] MUX_DIFF_HI = 5'h1d;
  localparam logic [9:0] SIGN_FLIP   = 10'h200;
  localparam logic [2:0] PS_MIN_CODE = 3'h1;

  typedef struct packed {
    logic              enable;
    logic              busy;
    logic              auto_en;
    logic              flag;
    logic              irq_en;
    logic [2:0]        ps_sel;
    logic [2:0]        ts_sel;
    logic              left;
    logic [4:0]        mux;
    logic [PIN_W-1:0]  pin_off;
    logic [RES_W-1:0]  result;
    logic              lock;
    logic              trig_prev;
    logic [PS_W-1:0]   ps_cnt;
    logic              clk_en;
    logic              start;
    logic [DATA_W-1:0] rdata;
    logic [PIN_W-1:0]  pin_s1;
    logic [PIN_W-1:0]  pin_s2;
    logic [PIN_W-1:0]  pin_val;
  } astrl_state_t;

endpackage : astrl_pkg

// *** logic/astrl_top.sv ***
// Converter control: flag, prescaler, auto trigger, result formatting, pin gating
`timescale 1ns/1ps
`default_nettype none

module astrl_top
  import astrl_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              global_irq_en_i,
  input  wire logic              irq_ack_i,
  output logic                   irq_o,
  input  wire logic [7:1]        trig_flags_i,
  output logic                   conv_enable_o,
  output logic                   conv_start_o,
  output logic                   conv_clk_en_o,
  input  wire logic              conv_done_i,
  input  wire logic [RES_W-1:0]  conv_data_i,
  output logic      [4:0]        input_sel_o,
  input  wire logic [PIN_W-1:0]  pin_i,
  output logic      [PIN_W-1:0]  pin_buffer_off_o,
  output logic      [PIN_W-1:0]  pin_value_o
);

  astrl_state_t state_reg;
  astrl_state_t state_next;

  // Divider terminal count for a prescaler code
  function automatic logic [PS_W-1:0] div_last(input logic [2:0] code);
    logic [7:0] span;
    span = 8'h01;
    if (code > PS_MIN_CODE) begin
      span = 8'(8'h01 << code);
    end else begin
      span = 8'h02;
    end
    return PS_W'(span - 8'h01);
  endfunction : div_last

  logic              wr_a;
  logic              wr_b;
  logic              rd_low;
  logic              rd_high;
  logic [7:0]        trig_vec;
  logic              trig_lvl;
  logic              trig_edge;
  logic              sw_start;
  logic              do_start;
  logic              is_diff;
  logic [RES_W-1:0]  res_fmt;
  logic [DATA_W-1:0] low_byte;
  logic [DATA_W-1:0] high_byte;
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    wr_a    = wr_i && (addr_i == OFS_CTRL_A);
    wr_b    = wr_i && (addr_i == OFS_CTRL_B);
    rd_low  = rd_i && (addr_i == OFS_RESULT_LOW);
    rd_high = rd_i && (addr_i == OFS_RESULT_HIGH);

    // Source 0 is the done flag itself, which gives free running
    trig_vec = {trig_flags_i, state_reg.flag};
    trig_lvl = trig_vec[state_reg.ts_sel];
    // A change of select is seen through the level compare, so a switch
    // onto a set source is an edge, except a switch onto free running
    trig_edge = trig_lvl && !state_reg.trig_prev
                && !(wr_b && (wdata_i[CB_TS_LSB +: 3] == TS_FREE_RUN));
    trig_edge = trig_edge && state_reg.auto_en;
    sw_start  = wr_a && wdata_i[CA_START];
    do_start  = state_reg.enable && !state_reg.busy && (sw_start || trig_edge);

    is_diff = (state_reg.mux >= MUX_DIFF_LO) && (state_reg.mux <= MUX_DIFF_HI);
    // Core delivers offset binary; flipping the top bit gives two's complement
    res_fmt = is_diff ? (conv_data_i ^ SIGN_FLIP) : conv_data_i;

    // Alignment is applied at read time so alignment changes act at once
    if (state_reg.left) begin
      high_byte = state_reg.result[9:2];
      low_byte  = {state_reg.result[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, state_reg.result[9:8]};
      low_byte  = state_reg.result[7:0];
    end

    case (addr_i)
      OFS_RESULT_LOW:  rd_mux = low_byte;
      OFS_RESULT_HIGH: rd_mux = high_byte;
      OFS_CTRL_A:      rd_mux = {state_reg.enable, state_reg.busy, state_reg.auto_en,
                                 state_reg.flag, state_reg.irq_en, state_reg.ps_sel};
      OFS_CTRL_B:      rd_mux = {5'h00, state_reg.ts_sel};
      OFS_INPUT_SEL:   rd_mux = {2'h0, state_reg.left, state_reg.mux};
      OFS_PIN_DISABLE: rd_mux = state_reg.pin_off;
      default:         rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    state_next       = state_reg;
    state_next.start = 1'b0;
    state_next.clk_en = 1'b0;
    state_next.trig_prev = trig_lvl;
    // A switch onto free running must not see a set done flag as an edge
    // in the cycle after the write either, so the old level is held high
    if (wr_b && (wdata_i[CB_TS_LSB +: 3] == TS_FREE_RUN)) begin
      state_next.trig_prev = 1'b1;
    end

    if (wr_a) begin
      state_next.enable  = wdata_i[CA_ENABLE];
      state_next.auto_en = wdata_i[CA_AUTO];
      state_next.irq_en  = wdata_i[CA_IE];
      state_next.ps_sel  = wdata_i[CA_PS_LSB +: 3];
    end
    if (wr_b) begin
      state_next.ts_sel = wdata_i[CB_TS_LSB +: 3];
    end
    if (wr_i && (addr_i == OFS_INPUT_SEL)) begin
      state_next.left = wdata_i[IS_LEFT];
      state_next.mux  = wdata_i[IS_MUX_LSB +: 5];
    end
    if (wr_i && (addr_i == OFS_PIN_DISABLE)) begin
      state_next.pin_off = wdata_i;
    end

    // Clears first so a finishing conversion in the same cycle wins
    if (irq_ack_i) begin
      state_next.flag = 1'b0;
    end
    if (wr_a && wdata_i[CA_FLAG]) begin
      state_next.flag = 1'b0;
    end

    if (do_start) begin
      state_next.start = 1'b1;
      state_next.busy  = 1'b1;
    end

    if (state_reg.busy && conv_done_i && state_reg.enable) begin
      state_next.busy = 1'b0;
      state_next.flag = 1'b1;
      // Frozen by a low byte read, including one in this very cycle
      if (!state_reg.lock && !rd_low) begin
        state_next.result = res_fmt;
      end
    end

    if (rd_low) begin
      state_next.lock = 1'b1;
    end
    if (rd_high) begin
      state_next.lock = 1'b0;
    end

    // Prescaler runs only while enabled; the core sees one pulse per tick
    if (state_reg.enable) begin
      if (state_reg.ps_cnt >= div_last(state_reg.ps_sel)) begin
        state_next.ps_cnt = '0;
        state_next.clk_en = 1'b1;
      end else begin
        state_next.ps_cnt = state_reg.ps_cnt + PS_W'(1);
      end
    end else begin
      state_next.ps_cnt = '0;
    end

    if (wr_a && !wdata_i[CA_ENABLE]) begin
      state_next.busy   = 1'b0;
      state_next.start  = 1'b0;
      state_next.ps_cnt = '0;
    end

    state_next.rdata   = rd_i ? rd_mux : 8'h00;
    state_next.pin_s1  = pin_i;
    state_next.pin_s2  = state_reg.pin_s1;
    state_next.pin_val = state_reg.pin_s2 & ~state_reg.pin_off;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o          = state_reg.rdata;
  assign irq_o            = state_reg.flag && state_reg.irq_en && global_irq_en_i;
  assign conv_enable_o    = state_reg.enable;
  assign conv_start_o     = state_reg.start;
  assign conv_clk_en_o    = state_reg.clk_en;
  assign input_sel_o      = state_reg.mux;
  assign pin_buffer_off_o = state_reg.pin_off;
  assign pin_value_o      = state_reg.pin_val;

endmodule : astrl_top

`default_nettype wire

// *** dv/astrl_props.sv ***
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module astrl_props
  import astrl_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rst_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              global_irq_en_i,
  input wire logic              irq_ack_i,
  input wire logic              irq_o,
  input wire logic              conv_enable_o,
  input wire logic              conv_start_o,
  input wire logic              conv_clk_en_o,
  input wire logic              conv_done_i,
  input wire logic [PIN_W-1:0]  pin_buffer_off_o,
  input wire logic [PIN_W-1:0]  pin_value_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  irq_global_a: assert property (irq_o |-> global_irq_en_i)
    else $error("irq raised without global enable");
  ack_clear_a: assert property (irq_ack_i && !conv_done_i |=> !irq_o)
    else $error("irq stays after vector entry");
  tick_gap_a: assert property (conv_clk_en_o |=> !conv_clk_en_o)
    else $error("converter tick faster than divide by 2");
  tick_off_a: assert property (!conv_enable_o && !$past(conv_enable_o) |-> !conv_clk_en_o)
    else $error("converter tick while disabled");
  start_en_a: assert property (conv_start_o |-> conv_enable_o)
    else $error("start while converter off");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  pin_mask_a: assert property ((pin_value_o & pin_buffer_off_o & $past(pin_buffer_off_o)) == 8'h00)
    else $error("disabled pin reads one");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without read strobe");
  cover property (irq_o);
  cover property (conv_start_o);
  cover property (rd_i ##1 rdata_o != 8'h00);
endmodule : astrl_props
bind astrl_top astrl_props u_props(.clock_i, .rst_i, .rd_i, .rdata_o, .global_irq_en_i,
  .irq_ack_i, .irq_o, .conv_enable_o, .conv_start_o, .conv_clk_en_o, .conv_done_i,
  .pin_buffer_off_o, .pin_value_o);
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import astrl_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, gie = 0, ack = 0, done = 0, irq, en, st, tick;
  logic [7:0] addr = 0, wdata = 0, pins = 0, rdata, boff, pval;
  logic [7:1] trig = '0;
  logic [9:0] data = 0, d, x;
  logic [4:0] isel, m;
  logic [15:0] v, lo;
  int mismatches = 0, check_count = 0, cyc = 0, n;
  always #20 clk = ~clk;
  astrl_top u_dut(.clock_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .global_irq_en_i(gie), .irq_ack_i(ack), .irq_o(irq),
    .trig_flags_i(trig), .conv_enable_o(en), .conv_start_o(st), .conv_clk_en_o(tick),
    .conv_done_i(done), .conv_data_i(data), .input_sel_o(isel), .pin_i(pins),
    .pin_buffer_off_o(boff), .pin_value_o(pval));
  task automatic chk(input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = {8'h00, rdata};
  endtask : rreg
  task automatic conv(input logic [9:0] c);
    @(posedge clk);
    done <= 1'b1;
    data <= c;
    @(posedge clk);
    done <= 1'b0;
  endtask : conv
  // Start may land a cycle or two after its cause, so a short window is scanned
  task automatic see_start(input logic e);
    n = 0;
    repeat (4) begin
      @(negedge clk);
      if (st === 1'b1) n = 1;
    end
    chk(16'(n), {15'h0, e});
  endtask : see_start
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic left);
    return left ? {c, 6'h00} : {6'h00, c};
  endfunction : fmt
  task automatic close_out;
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    void'($urandom(73862));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wreg(OFS_RESULT_LOW, 8'hff);
    for (int a = 8'h78; a < 8'h7e; a++) begin
      rreg(8'(a), v);
      chk(v, 16'h0000);
    end
    for (int p = 0; p < 8; p++) begin
      wreg(OFS_CTRL_A, 8'h80 | 8'(p));
      // The first gap after a change may be partial, so the third is measured
      repeat (3) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (tick !== 1'b1 && n < 300);
      end
      chk(16'(n), (p < 2) ? 16'h2 : 16'(1 << p));
    end
    for (int i = 0; i < 4; i++) begin
      d = 10'($urandom);
      m = i[1] ? MUX_DIFF_LO : 5'h00;
      x = i[1] ? d ^ SIGN_FLIP : d;
      gie <= i[0];
      wreg(OFS_INPUT_SEL, {2'b00, i[0], m});
      wreg(OFS_CTRL_A, 8'hc8); // whole-byte writes, never read-modify-write
      conv(d);
      rreg(OFS_CTRL_A, v);
      chk({v[4], irq}, {15'h0, i[0]} | 16'h2);
      rreg(OFS_RESULT_LOW, lo);
      rreg(OFS_RESULT_HIGH, v);
      chk({v[7:0], lo[7:0]}, fmt(x, i[0]));
      wreg(OFS_INPUT_SEL, {2'b00, ~i[0], m});
      rreg(OFS_RESULT_HIGH, v);
      chk({v[7:0], 8'h00}, fmt(x, ~i[0]) & 16'hff00);
      wreg(OFS_CTRL_A, 8'h88);
      rreg(OFS_CTRL_A, v);
      chk(v & 16'h10, 16'h10);
      if (i[0]) begin
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
      end else wreg(OFS_CTRL_A, 8'h98);
      rreg(OFS_CTRL_A, v);
      chk(v & 16'h10, 16'h00);
    end
    d = 10'($urandom);
    wreg(OFS_INPUT_SEL, 8'h00);
    wreg(OFS_CTRL_A, 8'hc0);
    conv(d);
    rreg(OFS_RESULT_LOW, lo);
    wreg(OFS_CTRL_A, 8'hd0);
    conv(~d);
    rreg(OFS_RESULT_HIGH, v);
    chk({v[7:0], lo[7:0]}, {6'h00, d});
    wreg(OFS_CTRL_A, 8'h80);
    wreg(OFS_CTRL_B, 8'h03); // reserved bits written as zero
    @(posedge clk);
    trig[3] <= 1'b1;
    see_start(1'b0);
    trig <= '0;
    wreg(OFS_CTRL_A, 8'ha0);
    for (int k = 1; k < 8; k++) begin
      wreg(OFS_CTRL_B, 8'(k));
      @(posedge clk);
      trig[k] <= 1'b1;
      see_start(1'b1);
      conv(10'($urandom));
      trig <= '0;
    end
    @(posedge clk);
    trig[1] <= 1'b1;
    wreg(OFS_CTRL_B, 8'h01);
    see_start(1'b1);
    conv(10'($urandom));
    // Old source cleared first, so only the set done flag could make an edge
    trig <= '0;
    wreg(OFS_CTRL_B, 8'h00);
    see_start(1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      pins <= 8'($urandom);
      wreg(OFS_PIN_DISABLE, i == 0 ? 8'hff : 8'($urandom));
      repeat (5) @(negedge clk);
      chk({boff, pval}, {wdata, pins & ~wdata});
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
